// File: verilog/sac_converter_ctrl.sv
// Functional notes
// - Format high gives straight binary, low gives two's complement.
// - Internal mode: a convert sends the previous result on 16 driven pulses.
// - External mode: host clocks the shift clock pin, data follows it.
// - Internal mode: 16 shift clock pulses per conversion, pin low between.
// - External mode: frame pulse on enable edge, timed to external clock.
// - External mode: chain input appears on data 16 pulses later.
// - Internal mode: each data bit stable across both shift clock edges.
// - Internal mode: between conversions data holds chain level from start.
// - Select low: read/convert falling edge holds sample and starts.
// - External mode, select low: read/convert rising edge enables serial shifting.
// - Select ORed with read/convert; select fall with it low starts.
// - External mode, read/convert high: select falling edge enables serial shifting.
// - Busy low during conversion; result valid when busy rises.
// - Power-down high blocks starts and keeps the previous result.
// - Start requests ignored while a conversion runs.
// - Approximation register cleared at each conversion start.
// - Result decided one bit at a time, MSB to LSB.
// - Completed result loaded into the output shift register.
`timescale 1ns/1ps
`default_nettype none

module sac_converter_ctrl
    import sac_pkg::*;
(
    // System clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset,
    // Host control pins
    input  wire logic                read_convert,
    input  wire logic                select_n,
    input  wire logic                shift_clock_source,
    input  wire logic                format_select,
    input  wire logic                power_down_input,
    input  wire logic                chain_tag,
    // Shift clock pin
    input  wire logic                shift_clock_pin_in,
    output logic                     shift_clock_pin_out,
    output logic                     shift_clock_pin_oe,
    // Serial outputs
    output logic                     serial_data,
    output logic                     frame_pulse,
    output logic                     busy_n,
    // Analog front end
    input  wire logic                cmp_keep,
    output logic [RESULT_W-1:0]      dac_code,
    output logic                     sample_hold
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    sac_pins_t pins_raw;
    sac_pins_t pin_s;
    logic      comb_n;
    logic      comb_d_r;
    logic      shen;
    logic      shen_d_r;
    logic      start_fall;
    logic      shen_rise;

    assign pins_raw = '{read_convert       : read_convert,
                        select_n           : select_n,
                        shift_clock_source : shift_clock_source,
                        format_select      : format_select,
                        power_down_input   : power_down_input,
                        chain_tag          : chain_tag};

    sac_sync2 #(.WIDTH($bits(sac_pins_t))) u_pin_sync (
        .clk      (sys_clk),
        .reset    (reset),
        .async_in (pins_raw),
        .sync_out (pin_s)
    );

    assign comb_n     = pin_s.select_n | pin_s.read_convert;
    assign shen       = ~pin_s.select_n & pin_s.read_convert;
    assign start_fall = comb_d_r & ~comb_n;
    assign shen_rise  = shen & ~shen_d_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Synced pins reset low, so a high here would fake a start on release
            comb_d_r <= 1'b0;
            shen_d_r <= 1'b0;
        end else begin
            comb_d_r <= comb_n;
            shen_d_r <= shen;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    localparam int STEP_W = $clog2(BIT_CYCLES);
    localparam logic [STEP_W-1:0]    STEP_LAST = STEP_W'(BIT_CYCLES - 1);
    localparam logic [BIT_IDX_W-1:0] BIT_MSB   = BIT_IDX_W'(RESULT_W - 1);

    sac_state_t            state_r;
    logic [STEP_W-1:0]     step_r;
    logic [BIT_IDX_W-1:0]  bit_r;
    logic                  again_r;
    logic                  start;
    logic                  conv_end;
    logic [RESULT_W-1:0]   sar_r;
    logic [RESULT_W-1:0]   final_bin;
    logic [RESULT_W-1:0]   out_sr_r;

    assign conv_end = (state_r == ST_CONV) && (bit_r == '0) && (step_r == STEP_LAST);
    assign start    = (state_r == ST_IDLE) && !pin_s.power_down_input
                      && (start_fall || again_r);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            step_r  <= '0;
            bit_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_CONV;
                        step_r  <= '0;
                        bit_r   <= BIT_MSB;
                    end
                end
                ST_CONV: begin
                    if (step_r == STEP_LAST) begin
                        step_r <= '0;
                        if (bit_r == '0) begin
                            state_r <= ST_IDLE;
                        end else begin
                            bit_r <= bit_r - 1'b1;
                        end
                    end else begin
                        step_r <= step_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Start lines still low when busy rises trigger a back-to-back conversion
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            again_r <= 1'b0;
        end else begin
            again_r <= conv_end && !comb_n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_n      <= 1'b1;
            sample_hold <= 1'b0;
        end else if (start) begin
            busy_n      <= 1'b0;
            sample_hold <= 1'b1;
        end else if (conv_end) begin
            busy_n      <= 1'b1;
            sample_hold <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Approximation register and output shift register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sar_r <= RESULT_RST;
        end else if (start) begin
            sar_r <= RESULT_RST;
        end else if (state_r == ST_CONV) begin
            if (step_r == '0) begin
                sar_r[bit_r] <= 1'b1;
            end else if (step_r == STEP_LAST) begin
                sar_r[bit_r] <= cmp_keep;
            end
        end
    end

    assign dac_code = sar_r;

    always_comb begin
        final_bin    = sar_r;
        final_bin[0] = cmp_keep;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_sr_r <= RESULT_RST;
        end else if (conv_end) begin
            // Two's complement is offset binary with the MSB inverted
            out_sr_r <= {final_bin[RESULT_W-1] ^ ~pin_s.format_select,
                         final_bin[RESULT_W-2:0]};
        end
    end

    // ------------------------------------------------------------------
    // Internal shift clock
    // ------------------------------------------------------------------
    localparam int DLY_W = $clog2(SCLK_DELAY_CYCLES + 1);
    localparam int PH_W  = $clog2(SCLK_CYCLES);
    localparam logic [DLY_W-1:0]     DLY_LAST = DLY_W'(SCLK_DELAY_CYCLES);
    localparam logic [PH_W-1:0]      PH_LAST  = PH_W'(SCLK_CYCLES - 1);
    localparam logic [PH_W-1:0]      PH_HIGH  = PH_W'(SCLK_HIGH_CYCLES);
    localparam logic [BIT_IDX_W:0]   PULSES   = (BIT_IDX_W+1)'(RESULT_W);

    logic                  int_mode_r;
    logic                  tag_hold_r;
    logic [DLY_W-1:0]      dly_r;
    logic [PH_W-1:0]       ph_r;
    logic [BIT_IDX_W:0]    pcnt_r;
    logic [RESULT_W-1:0]   tx_sr_r;
    logic                  serial_int_r;
    logic                  sclk_active;

    assign sclk_active = (state_r == ST_CONV) && int_mode_r && (dly_r == DLY_LAST)
                         && (pcnt_r != PULSES);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_mode_r <= 1'b0;
            tag_hold_r <= 1'b0;
        end else if (start) begin
            int_mode_r <= ~pin_s.shift_clock_source;
            tag_hold_r <= pin_s.chain_tag;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dly_r  <= '0;
            ph_r   <= '0;
            pcnt_r <= '0;
        end else if (start) begin
            dly_r  <= '0;
            ph_r   <= '0;
            pcnt_r <= '0;
        end else if (state_r == ST_CONV) begin
            if (dly_r != DLY_LAST) begin
                dly_r <= dly_r + 1'b1;
            end else if (sclk_active) begin
                if (ph_r == PH_LAST) begin
                    ph_r   <= '0;
                    pcnt_r <= pcnt_r + 1'b1;
                end else begin
                    ph_r <= ph_r + 1'b1;
                end
            end
        end
    end

    // Data changes one cycle before the clock rises and holds until after it falls
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_sr_r      <= RESULT_RST;
            serial_int_r <= 1'b0;
        end else if (start) begin
            tx_sr_r <= out_sr_r;
        end else if (sclk_active && ph_r == '0) begin
            serial_int_r <= tx_sr_r[RESULT_W-1];
            tx_sr_r      <= {tx_sr_r[RESULT_W-2:0], 1'b0};
        end else if (!sclk_active) begin
            serial_int_r <= tag_hold_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shift_clock_pin_out <= 1'b0;
            shift_clock_pin_oe  <= 1'b0;
        end else begin
            shift_clock_pin_out <= sclk_active && ph_r != '0 && ph_r <= PH_HIGH;
            shift_clock_pin_oe  <= ~pin_s.shift_clock_source;
        end
    end

    // ------------------------------------------------------------------
    // External shift clock hand-off
    // ------------------------------------------------------------------
    logic                ext_tog_r;
    logic                ext_gate_r;
    logic                ext_sel_r;
    logic [RESULT_W-1:0] ext_word_r;
    logic                serial_ext;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_tog_r  <= 1'b0;
            ext_word_r <= RESULT_RST;
        end else if (shen_rise && pin_s.shift_clock_source) begin
            ext_tog_r  <= ~ext_tog_r;
            ext_word_r <= out_sr_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_gate_r <= 1'b0;
            ext_sel_r  <= 1'b0;
        end else begin
            ext_gate_r <= shen && pin_s.shift_clock_source;
            ext_sel_r  <= pin_s.shift_clock_source;
        end
    end

    sac_ext_shifter u_ext (
        .link_clk        (shift_clock_pin_in),
        .reset           (reset),
        .load_toggle     (ext_tog_r),
        .shift_gate      (ext_gate_r),
        .load_word       (ext_word_r),
        .chain_tag       (chain_tag),
        .serial_data_ext (serial_ext),
        .frame_pulse     (frame_pulse)
    );

    assign serial_data = ext_sel_r ? serial_ext : serial_int_r;

endmodule

`default_nettype wire

// File: verilog/sac_pkg.sv
package sac_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RESULT_W = 16;
    localparam int BIT_IDX_W = $clog2(RESULT_W);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Timing (sys_clk at 40 MHz)
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 25;
    localparam int CONV_TIME_NS      = 3000;
    localparam int CONV_CYCLES       = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int BIT_CYCLES        = CONV_CYCLES / RESULT_W;
    localparam int SCLK_DELAY_NS     = 260;
    localparam int SCLK_DELAY_CYCLES = (SCLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_PERIOD_NS    = 150;
    localparam int SCLK_CYCLES       = SCLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SCLK_HIGH_CYCLES  = SCLK_CYCLES / 2;

    // ------------------------------------------------------------------
    // Host pins, sampled as one group
    // ------------------------------------------------------------------
    typedef struct packed {
        logic read_convert;
        logic select_n;
        logic shift_clock_source;
        logic format_select;
        logic power_down_input;
        logic chain_tag;
    } sac_pins_t;

    // ------------------------------------------------------------------
    // Conversion sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sac_state_t;

endpackage

// File: verilog/sac_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sac_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// File: verilog/sac_ext_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module sac_ext_shifter
    import sac_pkg::*;
(
    // Link clock and system reset
    input  wire logic                link_clk,
    input  wire logic                reset,
    // From the system domain
    input  wire logic                load_toggle,
    input  wire logic                shift_gate,
    input  wire logic [RESULT_W-1:0] load_word,
    // Chain input, timed to the link clock
    input  wire logic                chain_tag,
    // Link outputs
    output logic                     serial_data_ext,
    output logic                     frame_pulse
);

    // ------------------------------------------------------------------
    // Crossings into the link domain
    // ------------------------------------------------------------------
    logic                link_reset;
    logic [1:0]          ctl_s;
    logic                tog_d_r;
    logic                load_evt;
    logic [RESULT_W-1:0] sr_r;

    sac_sync2 #(.WIDTH(1)) u_rst_sync (
        .clk      (link_clk),
        .reset    (1'b0),
        .async_in (reset),
        .sync_out (link_reset)
    );

    sac_sync2 #(.WIDTH(2)) u_ctl_sync (
        .clk      (link_clk),
        .reset    (link_reset),
        .async_in ({load_toggle, shift_gate}),
        .sync_out (ctl_s)
    );

    assign load_evt = ctl_s[1] ^ tog_d_r;

    // ------------------------------------------------------------------
    // Shift register and frame pulse
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            tog_d_r <= 1'b0;
        end else begin
            tog_d_r <= ctl_s[1];
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            sr_r <= RESULT_RST;
        end else if (load_evt) begin
            sr_r <= load_word;
        end else if (ctl_s[0]) begin
            sr_r <= {sr_r[RESULT_W-2:0], chain_tag};
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            frame_pulse <= 1'b0;
        end else begin
            frame_pulse <= load_evt;
        end
    end

    assign serial_data_ext = sr_r[RESULT_W-1];

endmodule

`default_nettype wire

// File: verification/sac_converter_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sac_converter_ctrl_sva
    import sac_pkg::*;
(
    // Clocks and reset
    input wire logic                sys_clk,
    input wire logic                reset,
    input wire logic                shift_clock_pin_in,
    // Observed pins
    input wire logic                power_down_input,
    input wire logic                shift_clock_pin_out,
    input wire logic                shift_clock_pin_oe,
    input wire logic                serial_data,
    input wire logic                frame_pulse,
    input wire logic                busy_n,
    input wire logic [RESULT_W-1:0] dac_code,
    input wire logic                sample_hold
);
    logic [7:0] low_cnt_r;
    logic [4:0] pulse_cnt_r;

    // ------------------------------------------------------------------
    // Busy length and shift clock pulse counters
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || busy_n) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || $fell(busy_n)) begin
            pulse_cnt_r <= 5'h00;
        end else if ($rose(shift_clock_pin_out)) begin
            pulse_cnt_r <= pulse_cnt_r + 5'h01;
        end
    end

    sequence s_conv_start;
        $fell(busy_n);
    endsequence

    property p_conv_len;
        @(posedge sys_clk) disable iff (reset)
        $rose(busy_n) |-> (low_cnt_r >= 8'h6F && low_cnt_r <= 8'h71);
    endproperty
    property p_hold;
        @(posedge sys_clk) disable iff (reset) sample_hold == !busy_n;
    endproperty
    property p_sar_clear;
        @(posedge sys_clk) disable iff (reset) s_conv_start |-> dac_code == 16'h0000;
    endproperty
    property p_msb_trial;
        @(posedge sys_clk) disable iff (reset)
        s_conv_start |=> dac_code[15] && dac_code[14:0] == 15'h0000;
    endproperty
    property p_pd_block;
        @(posedge sys_clk) disable iff (reset)
        (power_down_input && $past(power_down_input) && $past(power_down_input, 2)
            && $past(power_down_input, 3) && busy_n) |=> busy_n;
    endproperty
    property p_clk_idle;
        @(posedge sys_clk) disable iff (reset) busy_n |-> !shift_clock_pin_out;
    endproperty
    property p_clk_owned;
        @(posedge sys_clk) disable iff (reset) shift_clock_pin_out |-> shift_clock_pin_oe;
    endproperty
    property p_data_stable;
        @(posedge sys_clk) disable iff (reset)
        (shift_clock_pin_out || $past(shift_clock_pin_out)) |-> $stable(serial_data);
    endproperty
    property p_pulses;
        @(posedge sys_clk) disable iff (reset)
        ($rose(busy_n) && shift_clock_pin_oe) |-> pulse_cnt_r == 5'h10;
    endproperty
    property p_frame_one;
        @(posedge shift_clock_pin_in) disable iff (reset) frame_pulse |=> !frame_pulse;
    endproperty

    a_conv_len: assert property (p_conv_len) else $error("busy low time wrong");
    a_hold: assert property (p_hold) else $error("hold not tied to busy");
    a_sar_clear: assert property (p_sar_clear) else $error("sar not cleared");
    a_msb_trial: assert property (p_msb_trial) else $error("msb not tried first");
    a_pd_block: assert property (p_pd_block) else $error("start while powered down");
    a_clk_idle: assert property (p_clk_idle) else $error("shift clock high when idle");
    a_clk_owned: assert property (p_clk_owned) else $error("clock without enable");
    a_data_stable: assert property (p_data_stable) else $error("data moved at edge");
    a_pulses: assert property (p_pulses) else $error("pulse count wrong");
    a_frame_one: assert property (p_frame_one) else $error("frame pulse too long");
endmodule

bind sac_converter_ctrl sac_converter_ctrl_sva i_sac_converter_ctrl_sva (
    .sys_clk, .reset, .shift_clock_pin_in, .power_down_input, .shift_clock_pin_out,
    .shift_clock_pin_oe, .serial_data, .frame_pulse, .busy_n, .dac_code, .sample_hold);

`default_nettype wire

// File: verification/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sac_host_model
    import sac_pkg::*;
(
    // Link clock control
    input  wire logic                run,
    output logic                     link_clk,
    // Analog side
    input  wire logic [RESULT_W-1:0] target,
    input  wire logic [RESULT_W-1:0] dac_code,
    output logic                     cmp_keep
);
    // Trial bit kept while the trial code does not exceed the input level
    assign cmp_keep = (dac_code <= target);

    // Host shift clock, parked low outside frames
    initial begin
        link_clk = 1'b0;
        #7;
        forever begin
            #24;
            if (run || link_clk) begin
                link_clk = ~link_clk;
            end
        end
    end
endmodule

`default_nettype wire

// File: verification/sar_adc_serial_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_serial_control_test
    import sac_pkg::*;
;
    logic                sys_clk            = 1'b0;
    logic                reset              = 1'b1;
    logic                read_convert       = 1'b1;
    logic                select_n           = 1'b1;
    logic                shift_clock_source = 1'b0;
    logic                format_select      = 1'b1;
    logic                power_down_input   = 1'b0;
    logic                chain_tag          = 1'b0;
    logic                run                = 1'b1;
    logic [RESULT_W-1:0] target             = 16'h0000;
    logic [RESULT_W-1:0] last_result        = RESULT_RST;
    logic [RESULT_W-1:0] dac_code;
    logic                link_clk, cmp_keep, pin_out, pin_oe, pin_wire;
    logic                serial_data, frame_pulse, busy_n, sample_hold;
    int                  n_mismatch         = 0;
    int                  n_compared         = 0;

    initial forever #12.5 sys_clk = ~sys_clk;

    sac_host_model i_sac_host_model (.run(run), .link_clk(link_clk), .target(target),
        .dac_code(dac_code), .cmp_keep(cmp_keep));

    // Shift clock pin level from whoever drives it
    assign pin_wire = pin_oe ? pin_out : link_clk;

    sac_converter_ctrl i_sac_converter_ctrl (.sys_clk(sys_clk), .reset(reset),
        .read_convert(read_convert), .select_n(select_n),
        .shift_clock_source(shift_clock_source), .format_select(format_select),
        .power_down_input(power_down_input), .chain_tag(chain_tag),
        .shift_clock_pin_in(pin_wire), .shift_clock_pin_out(pin_out),
        .shift_clock_pin_oe(pin_oe), .serial_data(serial_data), .frame_pulse(frame_pulse),
        .busy_n(busy_n), .cmp_keep(cmp_keep), .dac_code(dac_code), .sample_hold(sample_hold));

    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic convert(input logic [15:0] tgt, input logic fmt, input logic by_cs,
                           input logic chain);
        logic [15:0] word;
        int          pulses;
        int          low_cnt;
        logic        clk_q;
        word = 16'h0000;
        pulses = 0;
        low_cnt = 0;
        clk_q = 1'b0;
        @(posedge sys_clk);
        target <= tgt;
        format_select <= fmt;
        chain_tag <= chain;
        if (by_cs) begin
            read_convert <= 1'b0;
            repeat (2) @(posedge sys_clk);
            select_n <= 1'b0;
        end else begin
            select_n <= 1'b0;
            repeat (2) @(posedge sys_clk);
            read_convert <= 1'b0;
        end
        while (busy_n !== 1'b0 && low_cnt < 20) begin
            @(negedge sys_clk);
            low_cnt++;
        end
        check(busy_n === 1'b0, "conversion did not start");
        low_cnt = 1;
        fork
            begin
                @(posedge sys_clk);
                read_convert <= 1'b1;
                chain_tag <= ~chain;
                repeat (8) @(posedge sys_clk);
                read_convert <= 1'b0;
                repeat (8) @(posedge sys_clk);
                read_convert <= 1'b1;
                select_n <= 1'b1;
            end
            while (busy_n === 1'b0 && low_cnt < 200) begin
                @(negedge sys_clk);
                if (pin_out === 1'b1 && clk_q === 1'b0) begin
                    word = {word[14:0], serial_data};
                    pulses++;
                end
                clk_q = pin_out;
                if (busy_n === 1'b0) low_cnt++;
            end
        join
        check(pulses == 16, "shift clock pulse count");
        check(word === last_result, "internal serial word");
        check(low_cnt >= 108 && low_cnt <= 114, "busy low time");
        check(serial_data === chain, "idle data level");
        last_result = fmt ? tgt : tgt ^ 16'h8000;
        repeat (90) @(posedge sys_clk);
    endtask

    task automatic power_down_test();
        @(posedge sys_clk);
        power_down_input <= 1'b1;
        repeat (4) @(posedge sys_clk);
        select_n <= 1'b0;
        read_convert <= 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            check(busy_n === 1'b1, "start while powered down");
        end
        @(posedge sys_clk);
        select_n <= 1'b1;
        read_convert <= 1'b1;
        repeat (4) @(posedge sys_clk);
        power_down_input <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic ext_read(input logic during_conv, input logic [15:0] tgt);
        logic [19:0] bits;
        int          i;
        bits = 20'h00000;
        @(posedge sys_clk);
        shift_clock_source <= 1'b1;
        chain_tag <= 1'b1;
        target <= tgt;
        repeat (4) @(posedge sys_clk);
        if (during_conv) begin
            read_convert <= 1'b0;
            @(posedge sys_clk);
            select_n <= 1'b0;
            repeat (4) @(posedge sys_clk);
            read_convert <= 1'b1;
        end else begin
            select_n <= 1'b0;
        end
        run <= 1'b1;
        i = 0;
        while (frame_pulse !== 1'b1 && i < 12) begin
            @(negedge link_clk);
            i++;
        end
        check(frame_pulse === 1'b1, "frame pulse missing");
        for (i = 0; i < 20; i++) begin
            if (i > 0) @(negedge link_clk);
            bits = {bits[18:0], serial_data};
        end
        check(bits === {last_result, 4'hF}, "external serial data");
        @(posedge sys_clk);
        run <= 1'b0;
        select_n <= 1'b1;
        i = 0;
        while (during_conv && busy_n !== 1'b1 && i < 200) begin
            @(negedge sys_clk);
            i++;
        end
        if (during_conv) check(busy_n === 1'b1, "busy stuck low");
        if (during_conv) last_result = format_select ? tgt : tgt ^ 16'h8000;
        @(posedge sys_clk);
        shift_clock_source <= 1'b0;
        repeat (90) @(posedge sys_clk);
    endtask

    initial begin
        #200000;
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        run <= 1'b0;
        repeat (4) @(posedge sys_clk);
        convert(16'hA53C, 1'b1, 1'b0, 1'b1);
        convert(16'h1230, 1'b0, 1'b1, 1'b0);
        power_down_test();
        convert(16'hFFF0, 1'b1, 1'b0, 1'b0);
        ext_read(1'b0, 16'h0000);
        ext_read(1'b1, 16'h5A50);
        convert(16'h0001, 1'b0, 1'b1, 1'b1);
        convert(16'h0000, 1'b1, 1'b0, 1'b0);
        finish_test();
    end
endmodule

`default_nettype wire
